//--- rtl/tmr01_defs.svh
// How it works
// - Counter mode counts falling edges on pin
// - Events up to quarter clock rate counted
// - Prescaler codes: /12, /4, /48, ext/8
// - Per-timer select picks sysclk or prescaled
// - Timers 2/3 get sysclk, /12, ext/8
// - Timer 2 byte selects, high in split
// - Timer 3 byte selects, high in split
// - Each count is 16 bits, two bytes
// - Four mode codes per timer, set independently; split mode 3 holds the count
// - Mode 0 is 13 bits, five low
// - Wrap sets overflow flag and request
// - Counter select chooses pin or clock
// - Count needs run and gate condition
// - Run does not clear the count
// - Timer 1 gates on interrupt input 1
// - Requests pass only when enabled
// - Flag set by overflow, cleared by software/ack
`ifndef TMR01_DEFS_SVH
`define TMR01_DEFS_SVH

// ****************************************
// Register addresses
// ****************************************
`define TMR01_ADDR_CTRL 8'h88
`define TMR01_ADDR_MODE 8'h89
`define TMR01_ADDR_LOW0 8'h8a
`define TMR01_ADDR_LOW1 8'h8b
`define TMR01_ADDR_HIGH0 8'h8c
`define TMR01_ADDR_HIGH1 8'h8d
`define TMR01_ADDR_CLKSEL 8'h8e
`define TMR01_ADDR_IRQEN 8'ha8
`define TMR01_ADDR_EXTCFG 8'he4

// ****************************************
// Field positions
// ****************************************
`define TMR01_BIT_T3_HIGH 7
`define TMR01_BIT_T3_LOW 6
`define TMR01_BIT_T2_HIGH 5
`define TMR01_BIT_T2_LOW 4
`define TMR01_BIT_T1_SYS 3
`define TMR01_BIT_T0_SYS 2
`define TMR01_DIVSEL_HI 1
`define TMR01_DIVSEL_LO 0
`define TMR01_BIT_FLAG1 7
`define TMR01_BIT_RUN1 6
`define TMR01_BIT_FLAG0 5
`define TMR01_BIT_RUN0 4
`define TMR01_BIT_IRQEN0 1
`define TMR01_BIT_IRQEN1 3
`define TMR01_BIT_POL0 3
`define TMR01_BIT_POL1 7

// ****************************************
// Reset values and divide counts
// ****************************************
`define TMR01_RST_BYTE 8'h00
`define TMR01_DIV4 6'd4
`define TMR01_DIV12 6'd12
`define TMR01_DIV48 6'd48
`define TMR01_EXT_DIV 3'd7

`endif

//--- rtl/tmr01_pkg.sv
package tmr01_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } tmr01_sfr_req_t;

    typedef enum logic [1:0] {
        TMR01_MODE13 = 2'b00,
        TMR01_MODE16 = 2'b01,
        TMR01_MODE8AR = 2'b10,
        TMR01_MODESPLIT = 2'b11
    } tmr01_mode_t;

    typedef struct packed {
        logic gate_en;
        logic counter_sel;
        tmr01_mode_t mode;
    } tmr01_cfg_t;

    typedef enum logic [1:0] {
        TMR01_SCALE12 = 2'b00,
        TMR01_SCALE4 = 2'b01,
        TMR01_SCALE48 = 2'b10,
        TMR01_SCALEEXT = 2'b11
    } tmr01_scale_t;

endpackage

//--- rtl/tmr01_sync.sv
`timescale 1ns/1ns
module tmr01_sync #(
    parameter int W = 5
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= d;
            stage2_q <= stage1_q;
        end
    end

    assign q = stage2_q;
endmodule

//--- rtl/tmr01_top.sv
`timescale 1ns/1ns
`include "tmr01_defs.svh"
module tmr01_top
    import tmr01_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire tmr01_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata_q,
    input wire logic timer0_event_pin,
    input wire logic timer1_event_pin,
    input wire logic ext_irq0_in,
    input wire logic ext_irq1_in,
    input wire logic ext_osc_in,
    input wire logic timer0_irq_ack,
    input wire logic timer1_irq_ack,
    input wire logic timer2_ext_clk_choice,
    input wire logic timer3_ext_clk_choice,
    input wire logic timer2_split,
    input wire logic timer3_split,
    output logic timer0_irq_req_q,
    output logic timer1_irq_req_q,
    output logic timer2_low_tick_q,
    output logic timer2_high_tick_q,
    output logic timer3_low_tick_q,
    output logic timer3_high_tick_q
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic sfr_hit(input tmr01_sfr_req_t req,
                                     input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

    function automatic logic on_last(input logic [5:0] cnt,
                                     input logic [5:0] div);
        return (cnt % div) == (div - 6'd1);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] clksel_q;
    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    logic [7:0] irqen_q;
    logic [7:0] extcfg_q;
    logic [1:0] flag_q;
    logic [1:0] irq_req_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clksel_q <= `TMR01_RST_BYTE;
            ctrl_q <= `TMR01_RST_BYTE;
            mode_q <= `TMR01_RST_BYTE;
            irqen_q <= `TMR01_RST_BYTE;
            extcfg_q <= `TMR01_RST_BYTE;
        end else begin
            if (sfr_hit(sfr_req, `TMR01_ADDR_CLKSEL)) begin
                clksel_q <= sfr_req.wdata;
            end
            if (sfr_hit(sfr_req, `TMR01_ADDR_CTRL)) begin
                ctrl_q <= sfr_req.wdata;
            end
            if (sfr_hit(sfr_req, `TMR01_ADDR_MODE)) begin
                mode_q <= sfr_req.wdata;
            end
            if (sfr_hit(sfr_req, `TMR01_ADDR_IRQEN)) begin
                irqen_q <= sfr_req.wdata;
            end
            if (sfr_hit(sfr_req, `TMR01_ADDR_EXTCFG)) begin
                extcfg_q <= sfr_req.wdata;
            end
        end
    end

    // ****************************************
    // Pin sampling
    // ****************************************
    logic [4:0] sync_w;
    logic [1:0] pin_prev_q;
    logic osc_prev_q;
    logic [1:0] event_fall;
    logic osc_rise;

    // Inputs are meant to hold a level for two clocks
    tmr01_sync #(
        .W(5)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .d({ext_osc_in, ext_irq1_in, ext_irq0_in,
            timer1_event_pin, timer0_event_pin}),
        .q(sync_w)
    );

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_prev_q <= 2'b00;
            osc_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= sync_w[1:0];
            osc_prev_q <= sync_w[4];
        end
    end

    // One edge per clock is seen, so quarter rate leaves margin
    assign event_fall = pin_prev_q & ~sync_w[1:0];
    assign osc_rise = ~osc_prev_q & sync_w[4];

    // ****************************************
    // Prescaler
    // ****************************************
    logic [5:0] presc_cnt_q;
    logic [2:0] ext_div_q;
    logic div4_tick;
    logic div12_tick;
    logic div48_tick;
    logic ext8_tick;
    logic presc_tick;

    // One free-running base keeps the /4, /12 and /48 ticks aligned
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc_cnt_q <= 6'h00;
        end else if (presc_cnt_q == `TMR01_DIV48 - 6'd1) begin
            presc_cnt_q <= 6'h00;
        end else begin
            presc_cnt_q <= presc_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_div_q <= 3'h0;
        end else if (osc_rise) begin
            ext_div_q <= ext_div_q + 3'h1;
        end
    end

    assign div4_tick = on_last(presc_cnt_q, `TMR01_DIV4);
    assign div12_tick = on_last(presc_cnt_q, `TMR01_DIV12);
    assign div48_tick = on_last(presc_cnt_q, `TMR01_DIV48);
    assign ext8_tick = osc_rise && (ext_div_q == `TMR01_EXT_DIV);

    always_comb begin
        case (tmr01_scale_t'(clksel_q[`TMR01_DIVSEL_HI:`TMR01_DIVSEL_LO]))
            TMR01_SCALE12: presc_tick = div12_tick;
            TMR01_SCALE4: presc_tick = div4_tick;
            TMR01_SCALE48: presc_tick = div48_tick;
            TMR01_SCALEEXT: presc_tick = ext8_tick;
            default: presc_tick = 1'b0;
        endcase
    end

    // ****************************************
    // Timers 0 and 1
    // ****************************************
    tmr01_cfg_t cfg [2];
    logic [1:0] run;
    logic [1:0] sys_sel;
    logic [1:0] polarity;
    logic [1:0] irq_en;
    logic [1:0] gate_active;
    logic [1:0] run_ok;
    logic [1:0] tick;
    logic [1:0] ovf;
    logic [1:0] wr_cnt;
    logic [15:0] count [2];

    assign cfg[0] = mode_q[3:0];
    assign cfg[1] = mode_q[7:4];
    assign run = {ctrl_q[`TMR01_BIT_RUN1], ctrl_q[`TMR01_BIT_RUN0]};
    assign sys_sel = {clksel_q[`TMR01_BIT_T1_SYS],
                      clksel_q[`TMR01_BIT_T0_SYS]};
    assign polarity = {extcfg_q[`TMR01_BIT_POL1],
                       extcfg_q[`TMR01_BIT_POL0]};
    assign irq_en = {irqen_q[`TMR01_BIT_IRQEN1],
                     irqen_q[`TMR01_BIT_IRQEN0]};

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_unit
            localparam logic [7:0] LOW_ADDR =
                (i == 0) ? `TMR01_ADDR_LOW0 : `TMR01_ADDR_LOW1;
            localparam logic [7:0] HIGH_ADDR =
                (i == 0) ? `TMR01_ADDR_HIGH0 : `TMR01_ADDR_HIGH1;

            // Gate input i is interrupt input i, active at its polarity
            assign gate_active[i] = (sync_w[2+i] == polarity[i]);
            assign run_ok[i] = run[i] &&
                (!cfg[i].gate_en || gate_active[i]);
            // Clock select is ignored while counting pin events
            assign tick[i] = run_ok[i] && (cfg[i].counter_sel ?
                event_fall[i] : (sys_sel[i] || presc_tick));
            assign wr_cnt[i] = sfr_hit(sfr_req, LOW_ADDR) ||
                sfr_hit(sfr_req, HIGH_ADDR);

            tmr01_unit u_unit (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .tick(tick[i]),
                .mode(cfg[i].mode),
                .wr_low(sfr_hit(sfr_req, LOW_ADDR)),
                .wr_high(sfr_hit(sfr_req, HIGH_ADDR)),
                .wdata(sfr_req.wdata),
                .count(count[i]),
                .overflow(ovf[i])
            );
        end
    endgenerate

    // ****************************************
    // Overflow flags and requests
    // ****************************************
    logic ctrl_wr;
    logic [1:0] flag_wdata;

    assign ctrl_wr = sfr_hit(sfr_req, `TMR01_ADDR_CTRL);
    assign flag_wdata = {sfr_req.wdata[`TMR01_BIT_FLAG1],
                         sfr_req.wdata[`TMR01_BIT_FLAG0]};

    // Overflow beats a clear in the same cycle so no event is lost
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q <= 2'b00;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (ovf[k]) begin
                    flag_q[k] <= 1'b1;
                end else if (ctrl_wr) begin
                    flag_q[k] <= flag_wdata[k];
                end else if (k == 0 ? timer0_irq_ack : timer1_irq_ack) begin
                    flag_q[k] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req_q <= 2'b00;
        end else begin
            irq_req_q <= flag_q & irq_en;
        end
    end

    assign timer0_irq_req_q = irq_req_q[0];
    assign timer1_irq_req_q = irq_req_q[1];

    // ****************************************
    // Timers 2 and 3 clock selection
    // ****************************************
    logic [1:0] t23_low_sel;
    logic [1:0] t23_high_sel;
    logic [1:0] t23_ext;
    logic [1:0] t23_split;
    logic [1:0] t23_base;
    logic [1:0] t23_low_q;
    logic [1:0] t23_high_q;

    assign t23_low_sel = {clksel_q[`TMR01_BIT_T3_LOW],
                          clksel_q[`TMR01_BIT_T2_LOW]};
    assign t23_high_sel = {clksel_q[`TMR01_BIT_T3_HIGH],
                           clksel_q[`TMR01_BIT_T2_HIGH]};
    assign t23_ext = {timer3_ext_clk_choice, timer2_ext_clk_choice};
    assign t23_split = {timer3_split, timer2_split};

    genvar j;
    generate
        for (j = 0; j < 2; j++) begin : g_t23
            assign t23_base[j] = t23_ext[j] ? ext8_tick : div12_tick;

            // High byte follows the low select unless split
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    t23_low_q[j] <= 1'b0;
                    t23_high_q[j] <= 1'b0;
                end else begin
                    t23_low_q[j] <= t23_low_sel[j] || t23_base[j];
                    t23_high_q[j] <= t23_split[j] ?
                        (t23_high_sel[j] || t23_base[j]) :
                        (t23_low_sel[j] || t23_base[j]);
                end
            end
        end
    endgenerate

    assign timer2_low_tick_q = t23_low_q[0];
    assign timer2_high_tick_q = t23_high_q[0];
    assign timer3_low_tick_q = t23_low_q[1];
    assign timer3_high_tick_q = t23_high_q[1];

    // ****************************************
    // Read port
    // ****************************************
    logic [7:0] ctrl_view;

    always_comb begin
        ctrl_view = ctrl_q;
        ctrl_view[`TMR01_BIT_FLAG1] = flag_q[1];
        ctrl_view[`TMR01_BIT_FLAG0] = flag_q[0];
    end

    // Unmapped addresses read as zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata_q <= `TMR01_RST_BYTE;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                `TMR01_ADDR_CTRL: sfr_rdata_q <= ctrl_view;
                `TMR01_ADDR_MODE: sfr_rdata_q <= mode_q;
                `TMR01_ADDR_LOW0: sfr_rdata_q <= count[0][7:0];
                `TMR01_ADDR_LOW1: sfr_rdata_q <= count[1][7:0];
                `TMR01_ADDR_HIGH0: sfr_rdata_q <= count[0][15:8];
                `TMR01_ADDR_HIGH1: sfr_rdata_q <= count[1][15:8];
                `TMR01_ADDR_CLKSEL: sfr_rdata_q <= clksel_q;
                `TMR01_ADDR_IRQEN: sfr_rdata_q <= irqen_q;
                `TMR01_ADDR_EXTCFG: sfr_rdata_q <= extcfg_q;
                default: sfr_rdata_q <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_EDGE_COUNT: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cfg[0].counter_sel && cfg[0].mode == TMR01_MODE16 &&
         run_ok[0] && event_fall[0] && !wr_cnt[0])
        |=> count[0] == $past(count[0]) + 16'h0001)
        else $error("Falling edge did not advance count");

    AST_HOLD_STOPPED: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!run_ok[1] && !wr_cnt[1]) |=> $stable(count[1]))
        else $error("Stopped timer changed its count");

    AST_SYSCLK_SEL: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!cfg[0].counter_sel && sys_sel[0] && run_ok[0] &&
         (cfg[0].mode == TMR01_MODE13 || cfg[0].mode == TMR01_MODE16) &&
         !wr_cnt[0])
        |=> count[0] != $past(count[0]))
        else $error("System clock select did not count");

    AST_DIV4: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        div4_tick |=> (!div4_tick)[*3] ##1 div4_tick)
        else $error("Divide by four spacing wrong");

    AST_DIV12: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        div12_tick |-> ##12 div12_tick)
        else $error("Divide by twelve spacing wrong");

    AST_OVF_FLAG: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ovf[0] |=> flag_q[0] ##1 (irq_req_q[0] == $past(irq_en[0])))
        else $error("Overflow did not set flag or request");

    AST_IRQ_MASK: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !irq_en[1] |=> !irq_req_q[1])
        else $error("Masked request reached the output");

    AST_ACK_CLEAR: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (timer0_irq_ack && !ovf[0] && !ctrl_wr) |=> !flag_q[0])
        else $error("Acknowledge did not clear flag");

    AST_T2_SYSCLK: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        t23_low_sel[0] |=> timer2_low_tick_q)
        else $error("Timer 2 low byte lost system clock");

endmodule

//--- rtl/tmr01_unit.sv
`timescale 1ns/1ns
module tmr01_unit
    import tmr01_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire tmr01_mode_t mode,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    output logic [15:0] count,
    output logic overflow
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic ovf;

    always_comb begin
        cnt_d = cnt_q;
        ovf = 1'b0;
        if (tick) begin
            case (mode)
                TMR01_MODE13: begin
                    // Bits 7..5 of the low byte are left untouched
                    {cnt_d[15:8], cnt_d[4:0]} =
                        {cnt_q[15:8], cnt_q[4:0]} + 13'h0001;
                    ovf = &{cnt_q[15:8], cnt_q[4:0]};
                end
                TMR01_MODE16: begin
                    cnt_d = cnt_q + 16'h0001;
                    ovf = &cnt_q;
                end
                TMR01_MODE8AR: begin
                    ovf = &cnt_q[7:0];
                    cnt_d[7:0] = ovf ? cnt_q[15:8] : cnt_q[7:0] + 8'h01;
                end
                default: begin
                    cnt_d = cnt_q;
                end
            endcase
        end
        // Software load wins over a count in the same cycle
        if (wr_low) begin
            cnt_d[7:0] = wdata;
        end
        if (wr_high) begin
            cnt_d[15:8] = wdata;
        end
        if (wr_low || wr_high) begin
            ovf = 1'b0;
        end
    end

    // Run never resets the count; only ticks and loads change it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    assign overflow = ovf;

    AST_MODE13_WRAP: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (tick && mode == TMR01_MODE13 && !wr_low && !wr_high &&
         (&{cnt_q[15:8], cnt_q[4:0]}))
        |=> (cnt_q[15:8] == 8'h00 && cnt_q[4:0] == 5'h00))
        else $error("13-bit count did not wrap to zero");
endmodule

//--- verif/timer01_mode0_clock_select_tb_top.sv
`timescale 1ns/1ns
`include "tmr01_defs.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module timer01_mode0_clock_select_tb_top
    import tmr01_pkg::*;
;
    localparam int TEST_CYCLES = 4000;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    tmr01_sfr_req_t req = '0;
    logic [7:0] rdata;
    logic ack0 = 1'b0;
    logic ack1 = 1'b0;
    logic split2 = 1'b0;
    logic ext2 = 1'b0;
    logic irq0, irq1, t2l, t2h, t3l, t3h;
    logic ev0, ev1, g0, g1, osc;
    logic [7:0] d, hi;
    int n_fail = 0;
    int cmp_count = 0;

    tmr01_ext_model m (.sys_clk(sys_clk), .ev0(ev0), .ev1(ev1),
        .timer0_gate_en(g0), .gate1(g1), .osc(osc));

    tmr01_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_req(req),
        .sfr_rdata_q(rdata), .timer0_event_pin(ev0),
        .timer1_event_pin(ev1), .ext_irq0_in(g0), .ext_irq1_in(g1),
        .ext_osc_in(osc), .timer0_irq_ack(ack0), .timer1_irq_ack(ack1),
        .timer2_ext_clk_choice(ext2), .timer3_ext_clk_choice(1'b0),
        .timer2_split(split2), .timer3_split(1'b0),
        .timer0_irq_req_q(irq0), .timer1_irq_req_q(irq1),
        .timer2_low_tick_q(t2l), .timer2_high_tick_q(t2h),
        .timer3_low_tick_q(t3l), .timer3_high_tick_q(t3h));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Register access
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(posedge sys_clk);
        #1 v = rdata;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(`TMR01_ADDR_CLKSEL, d);
        `CHK("clksel reset", 8'h00, d)
        wr(`TMR01_ADDR_CLKSEL, 8'hff);
        rd(`TMR01_ADDR_CLKSEL, d);
        `CHK("clksel rw", 8'hff, d)
        wr(`TMR01_ADDR_CLKSEL, 8'h00);
        rd(8'h90, d);
        `CHK("unmapped", 8'h00, d)
        $display("test regs done");
    endtask

    task automatic t_count();
        // Sysclk select set on purpose: counter mode must ignore it
        wr(`TMR01_ADDR_CLKSEL, 8'h04);
        wr(`TMR01_ADDR_MODE, 8'h05);
        wr(`TMR01_ADDR_LOW0, 8'h00);
        wr(`TMR01_ADDR_HIGH0, 8'h00);
        wr(`TMR01_ADDR_CTRL, 8'h10);
        m.toggle(0, 5);
        repeat (6) @(posedge sys_clk);
        rd(`TMR01_ADDR_LOW0, d);
        `CHK("falls", 8'h05, d & 8'h1f)
        `CHK("ignored sel", 8'h05, d & 8'h1f)
        wr(`TMR01_ADDR_CTRL, 8'h00);
        m.toggle(0, 3);
        wr(`TMR01_ADDR_CTRL, 8'h10);
        repeat (6) @(posedge sys_clk);
        rd(`TMR01_ADDR_LOW0, d);
        `CHK("stopped", 8'h05, d & 8'h1f)
        $display("test count done");
    endtask

    task automatic t_gate();
        wr(`TMR01_ADDR_CTRL, 8'h00);
        wr(`TMR01_ADDR_MODE, 8'hc0);
        wr(`TMR01_ADDR_EXTCFG, 8'h80);
        wr(`TMR01_ADDR_LOW1, 8'h00);
        wr(`TMR01_ADDR_HIGH1, 8'h00);
        wr(`TMR01_ADDR_CTRL, 8'h40);
        m.toggle(1, 4);
        repeat (6) @(posedge sys_clk);
        rd(`TMR01_ADDR_LOW1, d);
        `CHK("gated off", 8'h00, d & 8'h1f)
        m.set_gate(1, 1'b1);
        repeat (4) @(posedge sys_clk);
        m.toggle(1, 4);
        repeat (6) @(posedge sys_clk);
        rd(`TMR01_ADDR_LOW1, d);
        `CHK("gated on", 8'h04, d & 8'h1f)
        wr(`TMR01_ADDR_EXTCFG, 8'h00);
        m.toggle(1, 4);
        repeat (6) @(posedge sys_clk);
        rd(`TMR01_ADDR_LOW1, d);
        `CHK("polarity", 8'h04, d & 8'h1f)
        m.set_gate(1, 1'b0);
        $display("test gate done");
    endtask

    task automatic t_ovf();
        wr(`TMR01_ADDR_CTRL, 8'h00);
        wr(`TMR01_ADDR_MODE, 8'h00);
        wr(`TMR01_ADDR_CLKSEL, 8'h04);
        wr(`TMR01_ADDR_IRQEN, 8'h02);
        wr(`TMR01_ADDR_HIGH0, 8'hff);
        wr(`TMR01_ADDR_LOW0, 8'h1f);
        wr(`TMR01_ADDR_CTRL, 8'h10);
        // Left running: the next wrap is 8192 ticks away
        rd(`TMR01_ADDR_CTRL, d);
        `CHK("flag", 8'h30, d)
        rd(`TMR01_ADDR_HIGH0, d);
        `CHK("wrap high", 8'h00, d)
        `CHK("request", 1'b1, irq0)
        @(posedge sys_clk);
        ack0 <= 1'b1;
        @(posedge sys_clk);
        ack0 <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("ack req", 1'b0, irq0)
        rd(`TMR01_ADDR_CTRL, d);
        `CHK("ack flag", 8'h10, d)
        wr(`TMR01_ADDR_IRQEN, 8'h00);
        wr(`TMR01_ADDR_CTRL, 8'h20);
        repeat (3) @(posedge sys_clk);
        `CHK("masked", 1'b0, irq0)
        wr(`TMR01_ADDR_IRQEN, 8'h08);
        wr(`TMR01_ADDR_CTRL, 8'h80);
        repeat (3) @(posedge sys_clk);
        `CHK("t1 request", 1'b1, irq1)
        @(posedge sys_clk);
        ack1 <= 1'b1;
        @(posedge sys_clk);
        ack1 <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("t1 ack", 1'b0, irq1)
        $display("test overflow done");
    endtask

    task automatic t_scale();
        int dv[3] = '{12, 4, 48};
        int c, e;
        for (int k = 0; k < 4; k++) begin
            wr(`TMR01_ADDR_CTRL, 8'h00);
            wr(`TMR01_ADDR_CLKSEL, 8'(k));
            wr(`TMR01_ADDR_LOW0, 8'h00);
            wr(`TMR01_ADDR_HIGH0, 8'h00);
            wr(`TMR01_ADDR_CTRL, 8'h10);
            if (k == 3) begin
                m.toggle(2, 48);
            end else begin
                repeat (480) @(posedge sys_clk);
            end
            wr(`TMR01_ADDR_CTRL, 8'h00);
            rd(`TMR01_ADDR_LOW0, d);
            rd(`TMR01_ADDR_HIGH0, hi);
            c = {hi, d[4:0]};
            e = (k == 3) ? 6 : 480 / dv[k];
            `CHK("prescale", 1'b1, c >= e - 1 && c <= e + 1)
        end
        $display("test prescale done");
    endtask

    task automatic t_t2();
        int n2, n3;
        n2 = 0;
        n3 = 0;
        split2 <= 1'b1;
        wr(`TMR01_ADDR_CLKSEL, 8'h70);
        repeat (2) @(posedge sys_clk);
        `CHK("t2 low sys", 1'b1, t2l)
        `CHK("t2 high sys", 1'b1, t2h)
        `CHK("t3 low sys", 1'b1, t3l)
        `CHK("t3 high", 1'b1, t3h)
        wr(`TMR01_ADDR_CLKSEL, 8'h00);
        repeat (2) @(posedge sys_clk);
        repeat (120) begin
            @(posedge sys_clk);
            #1 n2 += int'(t2l);
            n3 += int'(t3l);
        end
        `CHK("t2 div12", 1'b1, n2 >= 9 && n2 <= 11)
        `CHK("t3 div12", 1'b1, n3 >= 9 && n3 <= 11)
        @(posedge sys_clk);
        ext2 <= 1'b1;
        n2 = 0;
        fork
            m.toggle(2, 16);
            repeat (70) begin
                @(posedge sys_clk);
                #1 n2 += int'(t2l);
            end
        join
        `CHK("t2 ext8", 2, n2)
        $display("test aux timers done");
    endtask

    // ****************************************
    // Sequence and verdict
    // ****************************************
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_count();
        t_gate();
        t_ovf();
        t_scale();
        t_t2();
        complete_run();
    end

    initial begin
        #(TEST_CYCLES * 20 * 4);
        n_fail++;
        complete_run();
    end
endmodule

//--- verif/tmr01_ext_model.sv
`timescale 1ns/1ns
module tmr01_ext_model (
    input wire logic sys_clk,
    output logic ev0,
    output logic ev1,
    output logic timer0_gate_en,
    output logic gate1,
    output logic osc
);
    initial begin
        ev0 = 1'b1;
        ev1 = 1'b1;
        timer0_gate_en = 1'b0;
        gate1 = 1'b0;
        osc = 1'b0;
    end

    // ****************************************
    // Pin activity
    // ****************************************
    // Channel 2 is the oscillator; every level lasts two clocks, the
    // fastest rate the sampler is promised to follow
    task automatic toggle(input int ch, input int n);
        repeat (2 * n) begin
            @(posedge sys_clk);
            if (ch == 0) begin
                ev0 <= ~ev0;
            end else if (ch == 1) begin
                ev1 <= ~ev1;
            end else begin
                osc <= ~osc;
            end
            @(posedge sys_clk);
        end
    endtask

    task automatic set_gate(input int ch, input logic v);
        @(posedge sys_clk);
        if (ch == 0) begin
            timer0_gate_en <= v;
        end else begin
            gate1 <= v;
        end
    endtask
endmodule
